// ===== verilog/esm_regs.svh
// Constants of the display-identification source manager
`ifndef ESM_REGS_SVH
`define ESM_REGS_SVH

`define ESM_DDC_ADDR   7'h50
`define ESM_LINK_DEV   8'ha0
`define ESM_EDID_LAST  8'hff
`define ESM_CLK_MHZ    20
`define ESM_RETRY_US   1000
`define ESM_RETRY_CYC  (`ESM_RETRY_US * `ESM_CLK_MHZ)
`define ESM_MODE_RST   2'h3
`define ESM_STRAP_CYC  2'h3
`define ESM_SYNC_RST   16'hd800

`endif

// ===== verilog/esm_pkg.sv
// Types of the display-identification source manager
package esm_pkg;

   typedef enum logic [1:0]
   {
      ESM_MODE_LOCAL  = 2'h0,
      ESM_MODE_SRAM   = 2'h1,
      ESM_MODE_REMOTE = 2'h2,
      ESM_MODE_FUSE   = 2'h3
   } esm_mode_t;

   typedef enum logic [2:0]
   {
      ESM_DS_IDLE  = 3'h0,
      ESM_DS_ADDR  = 3'h1,
      ESM_DS_AACK  = 3'h3,
      ESM_DS_RBYTE = 3'h2,
      ESM_DS_MACK  = 3'h6,
      ESM_DS_WBYTE = 3'h7,
      ESM_DS_WACK  = 3'h5
   } esm_ddc_t;

   typedef enum logic [2:0]
   {
      ESM_SQ_FUSE  = 3'h0,
      ESM_SQ_IDLE  = 3'h1,
      ESM_SQ_RREQ  = 3'h3,
      ESM_SQ_RWAIT = 3'h2,
      ESM_SQ_RWR   = 3'h6,
      ESM_SQ_RETRY = 3'h7
   } esm_seq_t;

endpackage

// ===== verilog/esm_edid_ram.sv
// Identification memory: one write port, two registered read ports
`timescale 1ns/1ps
module esm_edid_ram
#(
   parameter int AW = 8,
   parameter int DW = 8
)
(
   input  wire logic          clk_i,
   input  wire logic          ce_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic [AW-1:0] raddr_a_i,
   output logic      [DW-1:0] rdata_a_o,
   input  wire logic [AW-1:0] raddr_b_i,
   output logic      [DW-1:0] rdata_b_o
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk_i)
   begin
      if (ce_i)
      begin
         if (we_i)
         begin
            mem[waddr_i] <= wdata_i;
         end
         rdata_a_o <= mem[raddr_a_i];
         rdata_b_o <= mem[raddr_b_i];
      end
   end

endmodule

// ===== verilog/esm_edid_source_manager.sv
// Display-identification source manager with DDC slave and HPD
//
// Overview of operation
// - Four identification sources: local EEPROM, loaded SRAM, remote, fuse.
// - Source chosen by strap pins or by the control override inputs.
// - DDC slave answers at byte address 0xA0 whenever it serves.
// - Local mode: stay off the DDC bus, enable the attached EEPROM.
// - Internal memory holds a 256-byte profile.
// - Host port rewrites and reads back the memory whenever the clock enable is high.
// - Remote mode: fetch from device 0xA0 over the control channel.
// - Remote bytes are copied into memory and served from there.
// - After reset the 256-byte fuse profile is copied into memory.
// - Fuse mode: DDC reads return the internal memory.
// - Fuse profile advertises 720p, two-channel audio, pixel clock up to 80 MHz.
// - HPD held low until ready, then released to the pull-up.
// - Control channel carries far-end I2C reads for this block.
`timescale 1ns/1ps
`include "esm_regs.svh"
module esm_edid_source_manager
#(
   parameter logic [15:0] MFR_ID    = 16'h1234, // Arbitrary value
   parameter int          RETRY_CYC = `ESM_RETRY_CYC
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic [1:0] mode_sel_i,
   input  wire logic       ctl_mode_ovr_i,
   input  wire logic [1:0] ctl_mode_i,
   input  wire logic       sram_valid_i,
   input  wire logic       pwr5v_i,
   input  wire logic       ddc_scl_i,
   input  wire logic       ddc_sda_i,
   output logic            ddc_sda_o,
   output logic            ddc_sda_oe_o,
   output logic            hpd_o,
   output logic            hpd_oe_o,
   output logic            local_eeprom_en_o,
   input  wire logic       host_we_i,
   input  wire logic       host_re_i,
   input  wire logic [7:0] host_addr_i,
   input  wire logic [7:0] host_wdata_i,
   output logic [7:0]      host_rdata_o,
   output logic            host_rvalid_o,
   input  wire logic       link_clk_i,
   input  wire logic       link_ack_i,
   input  wire logic       link_nak_i,
   input  wire logic [7:0] link_data_i,
   output logic            link_req_o,
   output logic [7:0]      link_dev_o,
   output logic [7:0]      link_addr_o
);

   localparam int RW = $clog2(RETRY_CYC + 1);

   // ----------------------------------------------------------------
   // Factory profile
   // ----------------------------------------------------------------
   localparam logic [2047:0] FUSE_ROM =
   {
      64'h00ffffffffffff00, MFR_ID, 48'h000901000000,
      128'h1c1801038034207_80aec18a354469825,
      128'h0f484c00000001010101010101010101,
      128'h010101010101011d007251d01e206e50,
      128'h5500002021000018000000fd003b3d62,
      128'h6408000a202020202020000000fc0048,
      128'h444d492d425249444745310a00000010,
      128'h00000000000000000000000000000157,
      128'h02031540418423097f05830100006603,
      128'h0c001000000000000000000000000000,
      760'h0, 8'h28
   };

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [15:0] sy1_q;
   logic [15:0] sy2_q;
   logic        scl_d_q;
   logic        sda_d_q;
   logic        lclk_d_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sy1_q    <= `ESM_SYNC_RST;
         sy2_q    <= `ESM_SYNC_RST;
         scl_d_q  <= 1'b1;
         sda_d_q  <= 1'b1;
         lclk_d_q <= 1'b0;
      end
      else if (ce_i)
      begin
         sy1_q    <= {mode_sel_i, pwr5v_i, ddc_scl_i, ddc_sda_i,
                      link_clk_i, link_ack_i, link_nak_i, link_data_i};
         sy2_q    <= sy1_q;
         scl_d_q  <= sy2_q[12];
         sda_d_q  <= sy2_q[11];
         lclk_d_q <= sy2_q[10];
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic link_edge;
   assign scl_rise  = sy2_q[12] & ~scl_d_q;
   assign scl_fall  = ~sy2_q[12] & scl_d_q;
   assign start     = sy2_q[12] & scl_d_q & sda_d_q & ~sy2_q[11];
   assign stop      = sy2_q[12] & scl_d_q & ~sda_d_q & sy2_q[11];
   assign link_edge = sy2_q[10] & ~lclk_d_q;

   // ----------------------------------------------------------------
   // Source selection and hot-plug
   // ----------------------------------------------------------------
   esm_pkg::esm_mode_t mode_q;
   logic [1:0]         strap_q;
   logic [1:0]         strap_cnt_q;
   logic               src_valid_q;
   logic               hpd_oe_q;
   logic               eeprom_en_q;
   logic               fuse_done_q;
   logic               remote_done_q;
   logic               serve;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         strap_q     <= `ESM_MODE_RST;
         strap_cnt_q <= 2'h0;
         mode_q      <= esm_pkg::esm_mode_t'(`ESM_MODE_RST);
      end
      else if (ce_i)
      begin
         if (strap_cnt_q != `ESM_STRAP_CYC)
         begin
            strap_q     <= sy2_q[15:14];
            strap_cnt_q <= strap_cnt_q + 2'h1;
         end
         mode_q <= esm_pkg::esm_mode_t'(ctl_mode_ovr_i ? ctl_mode_i
                                                       : strap_q);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         src_valid_q <= 1'b0;
         hpd_oe_q    <= 1'b1;
         eeprom_en_q <= 1'b0;
      end
      else if (ce_i)
      begin
         case (mode_q)
            esm_pkg::ESM_MODE_LOCAL:  src_valid_q <= 1'b1;
            esm_pkg::ESM_MODE_SRAM:   src_valid_q <= sram_valid_i;
            esm_pkg::ESM_MODE_REMOTE: src_valid_q <= remote_done_q;
            default:                  src_valid_q <= fuse_done_q;
         endcase
         hpd_oe_q    <= ~(sy2_q[13] & src_valid_q);
         eeprom_en_q <= (mode_q == esm_pkg::ESM_MODE_LOCAL);
      end
   end

   assign serve = (mode_q != esm_pkg::ESM_MODE_LOCAL) & src_valid_q;

   // ----------------------------------------------------------------
   // DDC slave
   // ----------------------------------------------------------------
   esm_pkg::esm_ddc_t ds_q;
   logic [3:0]        bit_q;
   logic [7:0]        sh_q;
   logic [7:0]        tx_q;
   logic              rw_q;
   logic [7:0]        offset_q;
   logic              sda_oe_q;
   logic [7:0]        rdata_a;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ds_q     <= esm_pkg::ESM_DS_IDLE;
         bit_q    <= 4'h0;
         sh_q     <= 8'h00;
         tx_q     <= 8'h00;
         rw_q     <= 1'b0;
         offset_q <= 8'h00;
         sda_oe_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (start)
         begin
            ds_q     <= esm_pkg::ESM_DS_ADDR;
            bit_q    <= 4'h0;
            sda_oe_q <= 1'b0;
         end
         else if (stop)
         begin
            ds_q     <= esm_pkg::ESM_DS_IDLE;
            sda_oe_q <= 1'b0;
         end
         else
         begin
            case (ds_q)
               esm_pkg::ESM_DS_ADDR, esm_pkg::ESM_DS_WBYTE:
                  if (scl_rise)
                  begin
                     sh_q  <= {sh_q[6:0], sy2_q[11]};
                     bit_q <= bit_q + 4'h1;
                  end
                  else if (scl_fall && bit_q == 4'h8)
                  begin
                     sda_oe_q <= 1'b1;
                     if (ds_q == esm_pkg::ESM_DS_WBYTE)
                     begin
                        offset_q <= sh_q;
                        ds_q     <= esm_pkg::ESM_DS_WACK;
                     end
                     else if (sh_q[7:1] == `ESM_DDC_ADDR && serve)
                     begin
                        rw_q <= sh_q[0];
                        ds_q <= esm_pkg::ESM_DS_AACK;
                     end
                     else
                     begin
                        sda_oe_q <= 1'b0;
                        ds_q     <= esm_pkg::ESM_DS_IDLE;
                     end
                  end
               esm_pkg::ESM_DS_AACK, esm_pkg::ESM_DS_WACK:
                  if (scl_fall)
                  begin
                     bit_q <= 4'h0;
                     if (ds_q == esm_pkg::ESM_DS_AACK && rw_q)
                     begin
                        tx_q     <= rdata_a;
                        sda_oe_q <= ~rdata_a[7];
                        ds_q     <= esm_pkg::ESM_DS_RBYTE;
                     end
                     else
                     begin
                        sda_oe_q <= 1'b0;
                        ds_q     <= esm_pkg::ESM_DS_WBYTE;
                     end
                  end
               esm_pkg::ESM_DS_RBYTE:
                  if (scl_fall)
                  begin
                     if (bit_q == 4'h7)
                     begin
                        sda_oe_q <= 1'b0;
                        offset_q <= offset_q + 8'h01;
                        ds_q     <= esm_pkg::ESM_DS_MACK;
                     end
                     else
                     begin
                        bit_q    <= bit_q + 4'h1;
                        tx_q     <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= ~tx_q[6];
                     end
                  end
               esm_pkg::ESM_DS_MACK:
                  if (scl_rise && sy2_q[11])
                  begin
                     ds_q <= esm_pkg::ESM_DS_IDLE;
                  end
                  else if (scl_fall)
                  begin
                     tx_q     <= rdata_a;
                     sda_oe_q <= ~rdata_a[7];
                     bit_q    <= 4'h0;
                     ds_q     <= esm_pkg::ESM_DS_RBYTE;
                  end
               default:
                  ds_q <= esm_pkg::ESM_DS_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Fuse load and remote copy
   // ----------------------------------------------------------------
   esm_pkg::esm_seq_t sq_q;
   logic [7:0]        seq_addr_q;
   logic [7:0]        seq_data_q;
   logic [RW-1:0]     retry_q;
   logic              req_q;
   logic              seq_step;
   logic [7:0]        fuse_byte;

   assign seq_step  = ~host_we_i;
   assign fuse_byte = FUSE_ROM[11'(2047 - 8 * int'(seq_addr_q)) -: 8];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sq_q          <= esm_pkg::ESM_SQ_FUSE;
         seq_addr_q    <= 8'h00;
         seq_data_q    <= 8'h00;
         retry_q       <= '0;
         req_q         <= 1'b0;
         fuse_done_q   <= 1'b0;
         remote_done_q <= 1'b0;
      end
      else if (ce_i)
      begin
         case (sq_q)
            esm_pkg::ESM_SQ_FUSE:
               if (seq_step)
               begin
                  seq_addr_q <= seq_addr_q + 8'h01;
                  if (seq_addr_q == `ESM_EDID_LAST)
                  begin
                     fuse_done_q <= 1'b1;
                     sq_q        <= esm_pkg::ESM_SQ_IDLE;
                  end
               end
            esm_pkg::ESM_SQ_IDLE:
               if (mode_q == esm_pkg::ESM_MODE_REMOTE && !remote_done_q)
               begin
                  seq_addr_q <= 8'h00;
                  sq_q       <= esm_pkg::ESM_SQ_RREQ;
               end
               else if (mode_q != esm_pkg::ESM_MODE_REMOTE)
               begin
                  remote_done_q <= 1'b0;
               end
            esm_pkg::ESM_SQ_RREQ:
               if (mode_q != esm_pkg::ESM_MODE_REMOTE)
               begin
                  sq_q <= esm_pkg::ESM_SQ_IDLE;
               end
               else
               begin
                  req_q <= 1'b1;
                  sq_q  <= esm_pkg::ESM_SQ_RWAIT;
               end
            esm_pkg::ESM_SQ_RWAIT:
               if (link_edge && sy2_q[9])
               begin
                  req_q      <= 1'b0;
                  seq_data_q <= sy2_q[7:0];
                  sq_q       <= esm_pkg::ESM_SQ_RWR;
               end
               else if (link_edge && sy2_q[8])
               begin
                  req_q      <= 1'b0;
                  retry_q    <= RW'(RETRY_CYC - 1);
                  sq_q       <= esm_pkg::ESM_SQ_RETRY;
               end
            esm_pkg::ESM_SQ_RWR:
               if (seq_step)
               begin
                  seq_addr_q <= seq_addr_q + 8'h01;
                  if (seq_addr_q == `ESM_EDID_LAST)
                  begin
                     remote_done_q <= 1'b1;
                     sq_q          <= esm_pkg::ESM_SQ_IDLE;
                  end
                  else
                  begin
                     sq_q <= esm_pkg::ESM_SQ_RREQ;
                  end
               end
            esm_pkg::ESM_SQ_RETRY:
               if (retry_q == '0)
               begin
                  seq_addr_q <= 8'h00;
                  sq_q       <= esm_pkg::ESM_SQ_RREQ;
               end
               else
               begin
                  retry_q <= retry_q - RW'(1);
               end
            default:
               sq_q <= esm_pkg::ESM_SQ_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Memory and host port
   // ----------------------------------------------------------------
   logic       ram_we;
   logic [7:0] ram_waddr;
   logic [7:0] ram_wdata;
   logic [7:0] rdata_b;
   logic       re_d_q;
   logic [7:0] host_rdata_q;
   logic       host_rvalid_q;

   always_comb
   begin
      ram_we    = host_we_i | (seq_step & (sq_q == esm_pkg::ESM_SQ_FUSE |
                                           sq_q == esm_pkg::ESM_SQ_RWR));
      ram_waddr = host_we_i ? host_addr_i : seq_addr_q;
      ram_wdata = host_we_i ? host_wdata_i :
                  (sq_q == esm_pkg::ESM_SQ_FUSE) ? fuse_byte : seq_data_q;
   end

   esm_edid_ram #(.AW(8), .DW(8)) u_ram
   (
      .clk_i     (clk_i),
      .ce_i      (ce_i),
      .we_i      (ram_we),
      .waddr_i   (ram_waddr),
      .wdata_i   (ram_wdata),
      .raddr_a_i (offset_q),
      .rdata_a_o (rdata_a),
      .raddr_b_i (host_addr_i),
      .rdata_b_o (rdata_b)
   );

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         re_d_q        <= 1'b0;
         host_rdata_q  <= 8'h00;
         host_rvalid_q <= 1'b0;
      end
      else if (ce_i)
      begin
         re_d_q        <= host_re_i;
         host_rvalid_q <= re_d_q;
         if (re_d_q)
         begin
            host_rdata_q <= rdata_b;
         end
      end
   end

   assign ddc_sda_o         = 1'b0;
   assign hpd_o             = 1'b0;
   assign ddc_sda_oe_o      = sda_oe_q;
   assign hpd_oe_o          = hpd_oe_q;
   assign local_eeprom_en_o = eeprom_en_q;
   assign host_rdata_o      = host_rdata_q;
   assign host_rvalid_o     = host_rvalid_q;
   assign link_req_o        = req_q;
   assign link_dev_o        = `ESM_LINK_DEV;
   assign link_addr_o       = seq_addr_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);

   AST_HPD_VALID: assert property (!hpd_oe_q |-> $past(src_valid_q))
      else $error("HPD released without valid source");
   AST_FUSE_DONE: assert property (
      $fell(sq_q == esm_pkg::ESM_SQ_FUSE)
      |-> fuse_done_q && $past(seq_addr_q) == 8'hff)
      else $error("Fuse load ended early");
   AST_DDC_ACK: assert property (
      (ds_q == esm_pkg::ESM_DS_ADDR && scl_fall
      && bit_q == 4'h8 && sh_q[7:1] == 7'h50 && serve && !start && !stop)
      |=> ds_q == esm_pkg::ESM_DS_AACK && sda_oe_q)
      else $error("DDC address 0xA0 not acknowledged");
   AST_LOCAL_QUIET: assert property (
      (ds_q == esm_pkg::ESM_DS_ADDR
      && mode_q == esm_pkg::ESM_MODE_LOCAL) |=> ds_q != esm_pkg::ESM_DS_AACK)
      else $error("DDC answered in local mode");
   AST_OFS_INC: assert property (
      (ds_q == esm_pkg::ESM_DS_RBYTE && scl_fall
      && bit_q == 4'h7 && !start && !stop)
      |=> offset_q == $past(offset_q) + 8'h01)
      else $error("Offset did not advance");
   AST_REQ_REMOTE: assert property ($rose(req_q)
      |-> $past(mode_q) == esm_pkg::ESM_MODE_REMOTE)
      else $error("Channel read outside remote mode");
   AST_COPY: assert property (
      (sq_q == esm_pkg::ESM_SQ_RWAIT && link_edge
      && sy2_q[9]) |=> seq_data_q == $past(sy2_q[7:0]) && !req_q)
      else $error("Remote byte not captured");
   AST_HOST_RD: assert property (host_re_i |-> ##2 host_rvalid_q)
      else $error("Host read not answered");

endmodule

// ===== verification/esm_ddc_source.sv
// DDC master model standing in for the video source
`timescale 1ns/1ps
module esm_ddc_source
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o,
   output logic      pwr5v_o
);
   logic [7:0] rd [8];

   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      pwr5v_o = 1'b0;
   end

   // Quarter bit, 8 core cycles
   task automatic q();
      repeat (8) @(posedge clk_i);
      #1;
   endtask

   task automatic power_up();
      q();
      pwr5v_o = 1'b1;
   endtask

   task automatic bit_io(input logic b, output logic s);
      sda_o = b;
      q();
      scl_o = 1'b1;
      q();
      s = sda_i;
      q();
      scl_o = 1'b0;
      q();
   endtask

   task automatic start();
      sda_o = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      sda_o = 1'b0;
      q();
      scl_o = 1'b0;
      q();
   endtask

   task automatic byte_io(input logic [7:0] d, input logic last,
                          output logic [7:0] r, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r[i]);
      bit_io(last, s);
      ack = !s;
   endtask

   // Offset write, repeated start, sequential read, stop
   task automatic xfer(input logic [7:0] dev, off, input int n,
                       output logic ok);
      logic       a;
      logic [7:0] r;
      start();
      byte_io(dev, 1'b1, r, ok);
      if (ok)
      begin
         byte_io(off, 1'b1, r, a);
         start();
         byte_io(dev | 8'h01, 1'b1, r, ok);
         ok = ok & a;
         for (int i = 0; i < n && ok; i++)
            byte_io(8'hff, i == n - 1, rd[i], a);
      end
      sda_o = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      sda_o = 1'b1;
      q();
   endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench of the identification source manager
`timescale 1ns/1ps
module testbench;
   logic       clk_i, rst_i, ce_i, ctl_mode_ovr_i, sram_valid_i, pwr5v_i;
   logic       ddc_scl_i, ddc_sda_i, ddc_sda_o, ddc_sda_oe_o, sda_m;
   logic       hpd_o, hpd_oe_o, local_eeprom_en_o, host_we_i, host_re_i;
   logic       host_rvalid_o, link_clk_i, link_ack_i, link_nak_i, link_req_o;
   logic [1:0] mode_sel_i, ctl_mode_i;
   logic [7:0] host_addr_i, host_wdata_i, host_rdata_o, link_data_i;
   logic [7:0] link_dev_o, link_addr_o, exp_off, a;
   logic [7:0] mem [4];
   logic [31:0] seed;
   logic       nak_once, ok;
   int         miscompares, n_compared, k;

   esm_edid_source_manager #(.RETRY_CYC(20)) dut
   (
      .clk_i, .rst_i, .ce_i, .mode_sel_i, .ctl_mode_ovr_i, .ctl_mode_i,
      .sram_valid_i, .pwr5v_i, .ddc_scl_i, .ddc_sda_i, .ddc_sda_o,
      .ddc_sda_oe_o, .hpd_o, .hpd_oe_o, .local_eeprom_en_o, .host_we_i,
      .host_re_i, .host_addr_i, .host_wdata_i, .host_rdata_o,
      .host_rvalid_o, .link_clk_i, .link_ack_i, .link_nak_i, .link_data_i,
      .link_req_o, .link_dev_o, .link_addr_o
   );

   esm_ddc_source src
   (
      .clk_i, .sda_i(ddc_sda_i), .scl_o(ddc_scl_i), .sda_o(sda_m),
      .pwr5v_o(pwr5v_i)
   );

   // Open-drain data line with pull-up
   assign ddc_sda_i = sda_m & (ddc_sda_oe_o ? ddc_sda_o : 1'b1);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] rem_byte(input logic [7:0] x);
      return {x[3:0], x[7:4]} ^ 8'h96;
   endfunction

   task automatic chk(input string what, input logic [7:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic ddc(input logic [7:0] dev, off, input int n,
                      input logic ack);
      src.xfer(dev, off, n, ok);
      chk("ddc_ack", 8'(ack), 8'(ok));
   endtask

   task automatic host_wr(input logic [7:0] ad, d);
      host_we_i = 1'b1;
      host_addr_i = ad;
      host_wdata_i = d;
      cyc(1);
      host_we_i = 1'b0;
      cyc(1);
   endtask

   task automatic host_rd(input logic [7:0] ad, e);
      int n;
      host_re_i = 1'b1;
      host_addr_i = ad;
      cyc(1);
      host_re_i = 1'b0;
      n = 0;
      while (host_rvalid_o !== 1'b1 && n < 4)
      begin
         cyc(1);
         n++;
      end
      chk("rvalid", 8'h01, 8'(host_rvalid_o));
      chk("rdata", e, host_rdata_o);
      cyc(1);
      chk("rvalid_end", 8'h00, 8'(host_rvalid_o));
   endtask

   // ------
   // Far-end responder, link clock runs only per answer
   // ------
   initial
   begin
      forever
      begin
         @(posedge clk_i iff link_req_o === 1'b1);
         #1;
         chk("link_dev", 8'ha0, link_dev_o);
         chk("link_addr", exp_off, link_addr_o);
         link_ack_i = !nak_once;
         link_nak_i = nak_once;
         link_data_i = rem_byte(link_addr_o);
         cyc(4);
         link_clk_i = 1'b1;
         cyc(4);
         link_clk_i = 1'b0;
         link_ack_i = 1'b0;
         link_nak_i = 1'b0;
         link_data_i = ~link_data_i;
         exp_off = nak_once ? 8'h00 : exp_off + 8'h01;
         nak_once = 1'b0;
      end
   end

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   initial
   begin
      repeat (90000) @(posedge clk_i);
      miscompares++;
      report_and_stop();
   end

   // ------
   // Main sequence
   // ------
   initial
   begin
      {rst_i, ce_i, mode_sel_i, ctl_mode_i} = 6'h3f;
      {ctl_mode_ovr_i, sram_valid_i, host_we_i, host_re_i} = 4'h0;
      {host_addr_i, host_wdata_i, link_data_i, exp_off} = 32'h0;
      {link_clk_i, link_ack_i, link_nak_i, nak_once} = 4'h0;
      miscompares = 0;
      n_compared = 0;
      seed = 32'hdb720716;
      cyc(6);
      rst_i = 1'b0;
      chk("hpd_rst", 8'h01, 8'(hpd_oe_o));
      cyc(400);
      chk("hpd_no5v", 8'h01, 8'(hpd_oe_o));
      src.power_up();
      cyc(8);
      chk("hpd_rel", 8'h00, 8'(hpd_oe_o));
      chk("hpd_lvl", 8'h00, 8'(hpd_o));
      chk("eeprom_off", 8'h00, 8'(local_eeprom_en_o));
      ddc(8'ha0, 8'h00, 8, 1'b1);
      for (int i = 0; i < 8; i++)
         chk("fuse", (i % 7 == 0) ? 8'h00 : 8'hff, src.rd[i]);
      ddc(8'ha0, 8'h7f, 2, 1'b1);
      chk("fuse_7f", 8'h57, src.rd[0]);
      chk("fuse_80", 8'h02, src.rd[1]);
      ddc(8'ha0, 8'hff, 2, 1'b1);
      chk("fuse_ff", 8'h28, src.rd[0]);
      chk("wrap", 8'h00, src.rd[1]);
      ddc(8'h60, 8'h00, 1, 1'b0);
      for (int i = 0; i < 16; i++)
      begin
         seed = lfsr(seed);
         a = (i == 15) ? 8'hff : seed[7:0];
         host_wr(a, seed[15:8]);
         host_rd(a, seed[15:8]);
      end
      // Clock enable low must block a host write
      host_wr(8'h3f, 8'h5a);
      ce_i = 1'b0;
      host_wr(8'h3f, 8'ha5);
      ce_i = 1'b1;
      host_rd(8'h3f, 8'h5a);
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         mem[i] = seed[7:0];
         host_wr(8'(8'h40 + i), mem[i]);
      end
      ddc(8'ha0, 8'h40, 4, 1'b1);
      for (int i = 0; i < 4; i++)
         chk("ddc_mem", mem[i], src.rd[i]);
      ctl_mode_ovr_i = 1'b1;
      ctl_mode_i = 2'h1;
      cyc(10);
      chk("hpd_sram", 8'h01, 8'(hpd_oe_o));
      ddc(8'ha0, 8'h40, 1, 1'b0);
      sram_valid_i = 1'b1;
      cyc(10);
      chk("hpd_sram_ok", 8'h00, 8'(hpd_oe_o));
      ddc(8'ha0, 8'h40, 1, 1'b1);
      chk("sram", mem[0], src.rd[0]);
      nak_once = 1'b1;
      ctl_mode_i = 2'h2;
      cyc(10);
      chk("hpd_rem", 8'h01, 8'(hpd_oe_o));
      k = 0;
      while (hpd_oe_o !== 1'b0 && k < 20000)
      begin
         cyc(1);
         k++;
      end
      chk("hpd_rem_ok", 8'h00, 8'(hpd_oe_o));
      chk("copy_len", 8'h00, exp_off);
      ddc(8'ha0, 8'hfe, 4, 1'b1);
      for (int i = 0; i < 4; i++)
         chk("remote", rem_byte(8'(8'hfe + i)), src.rd[i]);
      ctl_mode_ovr_i = 1'b0;
      mode_sel_i = 2'h0;
      rst_i = 1'b1;
      cyc(6);
      rst_i = 1'b0;
      cyc(10);
      chk("eeprom_en", 8'h01, 8'(local_eeprom_en_o));
      chk("hpd_local", 8'h00, 8'(hpd_oe_o));
      ddc(8'ha0, 8'h00, 1, 1'b0);
      report_and_stop();
   end
endmodule
